// ---- uhsp_map.svh ----
// Offsets, field positions, reset values and sizes of the schedule pointer register slice.
// Contract
// - Periodic base holds address bits 31..12.
// - Fetch address is base plus frame index.
// - Wide mode takes upper bits from segment.
// - Async register holds next queue head address.
// - Async reads return zero in bits 4..0.
// - Async pointer is treated 32-byte aligned.
// - Routing bit zero routes ports to companions.
// - Routing bit one routes ports here.
// - Frame index bits N..3 pick list entry.
`ifndef UHSP_MAP_SVH
`define UHSP_MAP_SVH
`define UHSP_OFS_PFLB 8'h34
`define UHSP_OFS_ASQ 8'h38
`define UHSP_OFS_RFLAG 8'h60
`define UHSP_PFLB_LSB 12
`define UHSP_ASQ_LSB 5
`define UHSP_CF_BIT 0
`define UHSP_RST_PFLB 20'h00000
`define UHSP_RST_ASQ 27'h0000000
`define UHSP_RST_CF 1'b0
`define UHSP_NUM_PORTS 4
`endif

// ---- uhsp_pkg.sv ----
// Types shared by the schedule pointer register slice.
package uhsp_pkg;
  typedef enum logic [1:0] {
    UHSP_FLS_1024 = 2'h0,
    UHSP_FLS_512 = 2'h1,
    UHSP_FLS_256 = 2'h2,
    UHSP_FLS_RSVD = 2'h3
  } uhsp_fls_e;
  typedef struct packed {
    logic [19:0] pflb;
    logic [26:0] asq;
    logic cf;
    logic [31:0] rdata;
    logic rvalid;
    logic [31:0] async_lo;
    logic [31:0] async_hi;
    logic [3:0] port_to_hs;
  } uhsp_regs_s;
  typedef struct packed {
    logic [31:0] fetch_lo;
    logic [31:0] fetch_hi;
  } uhsp_fetch_s;
endpackage

// ---- uhsp_fetch_addr.sv ----
// Periodic frame list fetch address former.
`timescale 1ns/100ps
`include "uhsp_map.svh"
module uhsp_fetch_addr
  import uhsp_pkg::*;
(
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Base, frame index and addressing mode.
  input wire logic [19:0] i_base,
  input wire logic [13:0] i_frame_index,
  input wire logic [1:0] i_frame_list_size_select,
  input wire logic i_wide_addressing_capable,
  input wire logic [31:0] i_upper_address_segment,
  // Fetch address.
  output logic [31:0] o_fetch_lo,
  output logic [31:0] o_fetch_hi
);
  uhsp_fetch_s s_q;
  uhsp_fetch_s s_d;

  // The reserved size code falls back to the largest list so no entry is skipped.
  function automatic logic [9:0] entry_sel(input logic [13:0] fi, input logic [1:0] fls);
    case (fls)
      UHSP_FLS_512: entry_sel = {1'b0, fi[11:3]};
      UHSP_FLS_256: entry_sel = {2'b00, fi[10:3]};
      default: entry_sel = fi[12:3];
    endcase
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.fetch_lo = {i_base, entry_sel(i_frame_index, i_frame_list_size_select), 2'b00};
    s_d.fetch_hi = i_wide_addressing_capable ? i_upper_address_segment : 32'h00000000;
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_fetch_lo = s_q.fetch_lo;
  assign o_fetch_hi = s_q.fetch_hi;

  property p_fetch_base;
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_rst_b |=> o_fetch_lo[31:12] == $past(i_base) && o_fetch_lo[1:0] == 2'b00;
  endproperty
  a_fetch_base: assert property (p_fetch_base) else $error("fetch base bits wrong");

  property p_entry_1024;
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_rst_b && i_frame_list_size_select == 2'h0 |=> o_fetch_lo[11:2] == $past(i_frame_index[12:3]);
  endproperty
  a_entry_1024: assert property (p_entry_1024) else $error("1024 entry select wrong");

  property p_entry_256;
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_rst_b && i_frame_list_size_select == 2'h2 |=>
      o_fetch_lo[11:10] == 2'b00 && o_fetch_lo[9:2] == $past(i_frame_index[10:3]);
  endproperty
  a_entry_256: assert property (p_entry_256) else $error("256 entry select wrong");

  property p_fetch_hi;
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_rst_b |=> o_fetch_hi == ($past(i_wide_addressing_capable) ? $past(i_upper_address_segment) : 32'h00000000);
  endproperty
  a_fetch_hi: assert property (p_fetch_hi) else $error("fetch upper bits wrong");

  c_wide_fetch: cover property (@(posedge i_mclk) disable iff (!i_rst_b) i_wide_addressing_capable ##1 o_fetch_hi != 0);
endmodule

// ---- uhsp_regs.sv ----
// Schedule pointer and port routing register slice of the high-speed host controller.
`timescale 1ns/100ps
`include "uhsp_map.svh"
module uhsp_regs
  import uhsp_pkg::*;
(
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Register access in operational memory space, byte offsets.
  input wire logic [7:0] i_addr,
  input wire logic i_wr,
  input wire logic [31:0] i_wdata,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_rvalid,
  // Frame counter, list size and addressing mode from neighbouring registers.
  input wire logic [13:0] i_micro_frame_counter,
  input wire logic [1:0] i_frame_list_size_select,
  input wire logic i_wide_addressing_capable,
  input wire logic [31:0] i_upper_address_segment,
  // Schedule addresses toward the list walker.
  output logic [31:0] o_periodic_fetch_lo,
  output logic [31:0] o_periodic_fetch_hi,
  output logic [31:0] o_async_queue_head_lo,
  output logic [31:0] o_async_queue_head_hi,
  // Default port ownership, one bit per port, high means this controller.
  output logic [`UHSP_NUM_PORTS-1:0] o_port_to_hs
);
  uhsp_regs_s r_q;
  uhsp_regs_s r_d;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  always_comb begin
    r_d = r_q;
    r_d.rvalid = i_rd;
    r_d.rdata = 32'h00000000;
    // A read in the same cycle as a write to the same register returns the old value.
    if (i_rd) begin
      if (hit(i_addr, `UHSP_OFS_PFLB)) begin
        r_d.rdata = {r_q.pflb, 12'h000};
      end else if (hit(i_addr, `UHSP_OFS_ASQ)) begin
        r_d.rdata = {r_q.asq, 5'h00};
      end else if (hit(i_addr, `UHSP_OFS_RFLAG)) begin
        r_d.rdata = {31'h00000000, r_q.cf};
      end
    end
    // Reserved bits are dropped on write, so stray ones never reach the walker.
    if (i_wr) begin
      if (hit(i_addr, `UHSP_OFS_PFLB)) begin
        r_d.pflb = i_wdata[31:`UHSP_PFLB_LSB];
      end else if (hit(i_addr, `UHSP_OFS_ASQ)) begin
        r_d.asq = i_wdata[31:`UHSP_ASQ_LSB];
      end else if (hit(i_addr, `UHSP_OFS_RFLAG)) begin
        r_d.cf = i_wdata[`UHSP_CF_BIT];
      end
    end
    r_d.async_lo = {r_q.asq, 5'h00};
    r_d.async_hi = i_wide_addressing_capable ? i_upper_address_segment : 32'h00000000;
    r_d.port_to_hs = {`UHSP_NUM_PORTS{r_q.cf}};
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      r_q <= '0;
      r_q.pflb <= `UHSP_RST_PFLB;
      r_q.asq <= `UHSP_RST_ASQ;
      r_q.cf <= `UHSP_RST_CF;
    end else begin
      r_q <= r_d;
    end
  end

  uhsp_fetch_addr u_fetch (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_base(r_q.pflb),
    .i_frame_index(i_micro_frame_counter),
    .i_frame_list_size_select(i_frame_list_size_select),
    .i_wide_addressing_capable(i_wide_addressing_capable),
    .i_upper_address_segment(i_upper_address_segment),
    .o_fetch_lo(o_periodic_fetch_lo),
    .o_fetch_hi(o_periodic_fetch_hi)
  );

  assign o_rdata = r_q.rdata;
  assign o_rvalid = r_q.rvalid;
  assign o_async_queue_head_lo = r_q.async_lo;
  assign o_async_queue_head_hi = r_q.async_hi;
  assign o_port_to_hs = r_q.port_to_hs;

  property p_pflb_low;
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_rd && i_addr == 8'h34 |=> o_rvalid && o_rdata[11:0] == 12'h000;
  endproperty
  a_pflb_low: assert property (p_pflb_low) else $error("periodic base low bits not zero");

  property p_pflb_back;
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_wr && i_addr == 8'h34 ##1 !i_wr ##1 i_rd && i_addr == 8'h34 |=> o_rdata[31:12] == $past(i_wdata[31:12], 3);
  endproperty
  a_pflb_back: assert property (p_pflb_back) else $error("periodic base readback wrong");

  property p_asq_low;
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_rd && i_addr == 8'h38 |=> o_rvalid && o_rdata[4:0] == 5'h00;
  endproperty
  a_asq_low: assert property (p_asq_low) else $error("async pointer low bits not zero");

  property p_asq_out;
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_wr && i_addr == 8'h38 |=> ##1 o_async_queue_head_lo[31:5] == $past(i_wdata[31:5], 2);
  endproperty
  a_asq_out: assert property (p_asq_out) else $error("queue head address not updated");

  property p_asq_align;
    @(posedge i_mclk) disable iff (!i_rst_b)
    o_async_queue_head_lo[4:0] == 5'h00;
  endproperty
  a_asq_align: assert property (p_asq_align) else $error("queue head not 32-byte aligned");

  property p_asq_hi;
    @(posedge i_mclk) disable iff (!i_rst_b)
    !i_wide_addressing_capable |=> o_async_queue_head_hi == 32'h00000000;
  endproperty
  a_asq_hi: assert property (p_asq_hi) else $error("upper bits used outside wide mode");

  property p_route_classic;
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_wr && i_addr == 8'h60 && !i_wdata[0] |=> ##1 o_port_to_hs == '0;
  endproperty
  a_route_classic: assert property (p_route_classic) else $error("ports not routed to companions");

  property p_route_hs;
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_wr && i_addr == 8'h60 && i_wdata[0] |=> ##1 o_port_to_hs == '1;
  endproperty
  a_route_hs: assert property (p_route_hs) else $error("ports not routed to this controller");

  // Read answers come exactly one cycle after the strobe and are zero otherwise.
  property p_rvalid_one;
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_rd |=> o_rvalid;
  endproperty
  a_rvalid_one: assert property (p_rvalid_one) else $error("read answer missing");

  property p_rvalid_idle;
    @(posedge i_mclk) disable iff (!i_rst_b)
    !i_rd |=> !o_rvalid && o_rdata == 32'h00000000;
  endproperty
  a_rvalid_idle: assert property (p_rvalid_idle) else $error("read answer without a read");

  property p_unmapped_read;
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_rd && i_addr != 8'h34 && i_addr != 8'h38 && i_addr != 8'h60 |=> o_rdata == 32'h00000000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped offset read nonzero");

  // Read data must match what the list walker is given in the same cycle.
  property p_pflb_read_fetch;
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_rd && i_addr == 8'h34 |=> o_rdata[31:12] == o_periodic_fetch_lo[31:12];
  endproperty
  a_pflb_read_fetch: assert property (p_pflb_read_fetch) else $error("periodic base read differs from fetch");

  property p_asq_read;
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_rd && i_addr == 8'h38 |=> o_rdata == o_async_queue_head_lo;
  endproperty
  a_asq_read: assert property (p_asq_read) else $error("async pointer read differs from queue head");

  // Software reads back after an idle cycle, so the written word is three samples old.
  property p_asq_back;
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_wr && i_addr == 8'h38 ##1 !i_wr ##1 i_rd && i_addr == 8'h38 |=> o_rdata[31:5] == $past(i_wdata[31:5], 3);
  endproperty
  a_asq_back: assert property (p_asq_back) else $error("async pointer readback wrong");

  property p_cf_back;
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_wr && i_addr == 8'h60 ##1 !i_wr ##1 i_rd && i_addr == 8'h60 |=> o_rdata[0] == $past(i_wdata[0], 3);
  endproperty
  a_cf_back: assert property (p_cf_back) else $error("routing flag readback wrong");

  // Only a write may move a pointer, so strobes to other offsets leave the walker alone.
  property p_pflb_hold;
    @(posedge i_mclk) disable iff (!i_rst_b)
    !(i_wr && i_addr == 8'h34) |=> ##1 $stable(o_periodic_fetch_lo[31:12]);
  endproperty
  a_pflb_hold: assert property (p_pflb_hold) else $error("periodic base moved without a write");

  property p_asq_hold;
    @(posedge i_mclk) disable iff (!i_rst_b)
    !(i_wr && i_addr == 8'h38) |=> ##1 $stable(o_async_queue_head_lo);
  endproperty
  a_asq_hold: assert property (p_asq_hold) else $error("queue head moved without a write");

  property p_asq_hi_wide;
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_rst_b && i_wide_addressing_capable |=> o_async_queue_head_hi == $past(i_upper_address_segment);
  endproperty
  a_asq_hi_wide: assert property (p_asq_hi_wide) else $error("queue head upper bits not from segment");

  // The routing outputs lag the flag by one cycle, so a read and the ports always agree.
  property p_cf_read;
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_rd && i_addr == 8'h60 |=> o_rdata == {31'h00000000, o_port_to_hs[0]};
  endproperty
  a_cf_read: assert property (p_cf_read) else $error("routing flag read differs from ports");

  property p_route_hold;
    @(posedge i_mclk) disable iff (!i_rst_b)
    !(i_wr && i_addr == 8'h60) |=> ##1 $stable(o_port_to_hs);
  endproperty
  a_route_hold: assert property (p_route_hold) else $error("port routing moved without a write");

  property p_ports_same;
    @(posedge i_mclk) disable iff (!i_rst_b)
    o_port_to_hs == '0 || o_port_to_hs == '1;
  endproperty
  a_ports_same: assert property (p_ports_same) else $error("ports routed apart");

  c_pflb_write: cover property (@(posedge i_mclk) disable iff (!i_rst_b) i_wr && i_addr == 8'h34);
  c_cf_set: cover property (@(posedge i_mclk) disable iff (!i_rst_b) $rose(o_port_to_hs[0]));
  c_asq_read: cover property (@(posedge i_mclk) disable iff (!i_rst_b) i_rd && i_addr == 8'h38 ##1 o_rdata != 0);
  c_unmapped_read: cover property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_rd && i_addr != 8'h34 && i_addr != 8'h38 && i_addr != 8'h60);
endmodule

// ---- test_usb_host_schedule_pointer_regs.sv ----
// Self-checking bench for the schedule pointer and port routing register slice.
`timescale 1ns/100ps
`include "uhsp_map.svh"
module test_usb_host_schedule_pointer_regs;
  logic i_mclk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic i_wr = 1'b0;
  logic [31:0] i_wdata = 32'h0;
  logic i_rd = 1'b0;
  logic [13:0] i_micro_frame_counter = 14'h0;
  logic [1:0] i_frame_list_size_select = 2'h0;
  logic i_wide_addressing_capable = 1'b0;
  logic [31:0] i_upper_address_segment = 32'h0;
  logic [31:0] o_rdata, o_periodic_fetch_lo, o_periodic_fetch_hi, o_async_queue_head_lo, o_async_queue_head_hi;
  logic o_rvalid;
  logic [3:0] o_port_to_hs;
  logic [31:0] rd_val;
  int miscompares = 0;
  int tests_run = 0;

  uhsp_regs i_dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wr(i_wr), .i_wdata(i_wdata),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .i_micro_frame_counter(i_micro_frame_counter),
    .i_frame_list_size_select(i_frame_list_size_select), .i_wide_addressing_capable(i_wide_addressing_capable),
    .i_upper_address_segment(i_upper_address_segment), .o_periodic_fetch_lo(o_periodic_fetch_lo),
    .o_periodic_fetch_hi(o_periodic_fetch_hi), .o_async_queue_head_lo(o_async_queue_head_lo),
    .o_async_queue_head_hi(o_async_queue_head_hi), .o_port_to_hs(o_port_to_hs));

  initial begin
    forever #5 i_mclk = ~i_mclk;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      miscompares++;
    end
  endtask

  task wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  // The answer is awaited for a few cycles only, so a silent bus ends the run.
  task rd_reg(input logic [7:0] a, output logic [31:0] d);
    int n;
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(negedge i_mclk);
    for (n = 0; n < 3 && o_rvalid !== 1'b1; n++) @(negedge i_mclk);
    if (o_rvalid !== 1'b1) begin
      miscompares++;
      $display("CHECK FAILED at %0t: no read answer", $time);
      wrap_up();
    end
    d = o_rdata;
  endtask

  task settle();
    repeat (3) @(posedge i_mclk);
    @(negedge i_mclk);
  endtask

  task fetch(input logic [1:0] fls, input logic [13:0] idx, input logic [9:0] mask, input logic [19:0] base);
    @(posedge i_mclk);
    i_frame_list_size_select <= fls;
    i_micro_frame_counter <= idx;
    settle();
    check(o_periodic_fetch_lo, {base, idx[12:3] & mask, 2'b00});
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    rd_reg(a, rd_val);
    check(rd_val, exp);
  endtask

  initial begin
    repeat (12) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    rd_chk(`UHSP_OFS_PFLB, 32'h0);
    rd_chk(`UHSP_OFS_ASQ, 32'h0);
    rd_chk(`UHSP_OFS_RFLAG, 32'h0);
    check({28'h0, o_port_to_hs}, 32'h0);
    // Base is programmed before any fetch is judged, as software must do.
    wr_reg(`UHSP_OFS_PFLB, 32'habcde000);
    rd_chk(`UHSP_OFS_PFLB, 32'habcde000);
    fetch(2'h0, 14'h3ffd, 10'h3ff, 20'habcde);
    fetch(2'h1, 14'h3ffd, 10'h1ff, 20'habcde);
    fetch(2'h2, 14'h3ffd, 10'h0ff, 20'habcde);
    fetch(2'h3, 14'h3ffd, 10'h3ff, 20'habcde);
    fetch(2'h0, 14'h0123, 10'h3ff, 20'habcde);
    wr_reg(`UHSP_OFS_ASQ, 32'h1234567f);
    rd_chk(`UHSP_OFS_ASQ, 32'h12345660);
    settle();
    check(o_async_queue_head_lo, 32'h12345660);
    @(posedge i_mclk);
    i_wide_addressing_capable <= 1'b1;
    i_upper_address_segment <= 32'h89abcdef;
    settle();
    check(o_periodic_fetch_hi, 32'h89abcdef);
    check(o_async_queue_head_hi, 32'h89abcdef);
    @(posedge i_mclk);
    i_wide_addressing_capable <= 1'b0;
    settle();
    check(o_periodic_fetch_hi, 32'h0);
    check(o_async_queue_head_hi, 32'h0);
    wr_reg(8'h3c, 32'hffffffff);
    rd_chk(8'h3c, 32'h0);
    rd_chk(`UHSP_OFS_PFLB, 32'habcde000);
    rd_chk(`UHSP_OFS_ASQ, 32'h12345660);
    // The flag goes last, after both pointers are in place.
    wr_reg(`UHSP_OFS_RFLAG, 32'h00000001);
    rd_chk(`UHSP_OFS_RFLAG, 32'h1);
    settle();
    check({28'h0, o_port_to_hs}, 32'hf);
    wr_reg(`UHSP_OFS_RFLAG, 32'h0);
    settle();
    check({28'h0, o_port_to_hs}, 32'h0);
    wr_reg(`UHSP_OFS_RFLAG, 32'h1);
    @(posedge i_mclk);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    rd_chk(`UHSP_OFS_PFLB, 32'h0);
    rd_chk(`UHSP_OFS_ASQ, 32'h0);
    rd_chk(`UHSP_OFS_RFLAG, 32'h0);
    check({28'h0, o_port_to_hs}, 32'h0);
    wrap_up();
  end
endmodule
